// ### rtl/ufsi_pkg.sv
// Purpose: Shared constants and carriers for the USB status/irq block.
// Assumes: Avalon-MM byte addresses, 8-bit registers in byte lane 0.
// Notes:   All numbers used by the logic except the NUM_EP and W parameter defaults are named here.
package ufsi_pkg;
    // ==========================================================
    // Bus geometry
    localparam int AW = 20;
    localparam int DW = 32;
    localparam int RW = 8;
    // ==========================================================
    // Register byte addresses
    localparam logic [AW-1:0] BUS_STATE_ADDR  = 20'hf0548;
    localparam logic [AW-1:0] HALT_STAT_ADDR  = 20'hf054c;
    localparam logic [AW-1:0] SRC_FIRST_ADDR  = 20'hf0550;
    localparam logic [AW-1:0] CLR_FIRST_ADDR  = 20'hf0554;
    localparam logic [AW-1:0] SET_TGT_ADDR    = 20'hf0558;
    localparam logic [AW-1:0] CLR_TGT_ADDR    = 20'hf055c;
    localparam logic [AW-1:0] STALL_FRC_ADDR  = 20'hf0560;
    // ==========================================================
    // Field positions and reset values
    localparam int SUSP_BIT     = 7;
    localparam int BUS_RST_BIT  = 7;
    localparam int RSUSP_BIT    = 6;
    localparam int SET_RQ_BIT   = 2;
    localparam int CLR_RQ_BIT   = 1;
    localparam int STALL_BIT    = 0;
    localparam int EP0_BIT      = 0;
    localparam logic [RW-1:0] REG_RST  = 8'h00;
    localparam logic [RW-1:0] SRC_MASK = 8'hc7;
    localparam logic [DW-1:0] RD_ZERO  = 32'h0000_0000;
    // ==========================================================
    // Event pulses from the serial interface engine, one cycle each
    typedef struct packed {
        logic          bus_reset;
        logic          suspend;
        logic          resume;
        logic          set_done;
        logic [RW-1:0] set_target;
        logic          set_feat_ep;
        logic          clr_done;
        logic [RW-1:0] clr_target;
        logic [RW-1:0] stall_vec;
        logic [RW-1:0] halt_clr_vec;
        logic          setup_token;
        logic          ep0_mask_req;
    } ufsi_evt_s;
    // Avalon-MM request from the master
    typedef struct packed {
        logic          read;
        logic          write;
        logic [AW-1:0] address;
        logic [DW-1:0] writedata;
        logic [3:0]    byteenable;
    } ufsi_avm_req_s;
endpackage

// ### rtl/ufsi_flag_bank.sv
// Purpose: Bank of sticky flags, set by hardware, cleared by software.
// Assumes: set and clear vectors are one-cycle pulses on clk.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/10ps
module ufsi_flag_bank #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set_vec,
    input  wire logic [W-1:0] clr_vec,
    output logic      [W-1:0] flags
);
    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    always_comb begin
        flags_next = (flags_reg & ~clr_vec) | set_vec;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// ### rtl/ufsi_status_irq.sv
// Purpose: Bus state, first interrupt source and endpoint halt status.
// Assumes: Events arrive from logic on clk; Avalon-MM slave, one wait.
// Notes:   Read side effects happen at the edge where data is captured.
`timescale 1ns/10ps
module ufsi_status_irq #(
    parameter int NUM_EP = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire ufsi_pkg::ufsi_avm_req_s avm,
    output logic [ufsi_pkg::DW-1:0]   avm_readdata,
    output logic                      avm_waitrequest,
    input  wire ufsi_pkg::ufsi_evt_s  evt,
    input  wire logic [NUM_EP-1:0]    endpoint_enable_setting,
    input  wire logic                 second_sources_any,
    output logic                      combined_usb_irq
);
    // ==========================================================
    // Elaboration check
    if (NUM_EP < 1 || NUM_EP > ufsi_pkg::RW) begin : g_bad_ep
        $error("NUM_EP must lie between 1 and 8");
    end

    // ==========================================================
    // Bus slave handshake
    logic                    wait_reg;
    logic [ufsi_pkg::DW-1:0] rdata_reg;
    logic                    req;
    logic                    cap;
    logic                    acc_wr;
    logic                    rd_bus_state;
    logic                    wr_clr;
    logic                    wr_force;
    logic [ufsi_pkg::RW-1:0] wbyte;

    function automatic logic hit(input logic [ufsi_pkg::AW-1:0] a,
                                 input logic [ufsi_pkg::AW-1:0] r);
        hit = (a == r);
    endfunction

    assign req          = avm.read | avm.write;
    assign cap          = req & wait_reg;
    assign acc_wr       = avm.write & ~wait_reg & avm.byteenable[0];
    assign wbyte        = avm.writedata[ufsi_pkg::RW-1:0];
    assign rd_bus_state = avm.read & wait_reg
                        & hit(avm.address, ufsi_pkg::BUS_STATE_ADDR);
    assign wr_clr       = acc_wr & hit(avm.address, ufsi_pkg::CLR_FIRST_ADDR);
    assign wr_force     = acc_wr & hit(avm.address, ufsi_pkg::STALL_FRC_ADDR);

    // Waitrequest drops for exactly one cycle per request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~cap;
        end
    end

    // ==========================================================
    // Suspend state
    logic susp_reg;

    // A suspend event beats a resume or the read clear in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            susp_reg <= 1'b0;
        end else if (evt.suspend) begin
            susp_reg <= 1'b1;
        end else if (evt.resume || rd_bus_state) begin
            susp_reg <= 1'b0;
        end
    end

    // ==========================================================
    // First interrupt source flags
    logic [ufsi_pkg::RW-1:0] src_set;
    logic [ufsi_pkg::RW-1:0] src_clr;
    logic [ufsi_pkg::RW-1:0] src_flags;
    logic                    stall_any;
    logic                    force_any;

    assign force_any = wr_force & (|wbyte);
    assign stall_any = (|evt.stall_vec) | evt.set_feat_ep | force_any;

    always_comb begin
        src_set = ufsi_pkg::REG_RST;
        src_set[ufsi_pkg::BUS_RST_BIT] = evt.bus_reset;
        src_set[ufsi_pkg::RSUSP_BIT]   = evt.suspend | evt.resume;
        src_set[ufsi_pkg::SET_RQ_BIT]  = evt.set_done;
        src_set[ufsi_pkg::CLR_RQ_BIT]  = evt.clr_done;
        src_set[ufsi_pkg::STALL_BIT]   = stall_any;
    end

    // Only a written zero clears; reads and bus events never do.
    always_comb begin
        src_clr = ufsi_pkg::REG_RST;
        if (wr_clr) begin
            src_clr = ~wbyte & ufsi_pkg::SRC_MASK;
        end
    end

    ufsi_flag_bank #(
        .W (ufsi_pkg::RW)
    ) u_src (
        .clk     (clk),
        .rst_n   (rst_n),
        .set_vec (src_set),
        .clr_vec (src_clr),
        .flags   (src_flags)
    );

    // ==========================================================
    // Request targets, kept until the next request of the same kind
    logic [ufsi_pkg::RW-1:0] set_tgt_reg;
    logic [ufsi_pkg::RW-1:0] clr_tgt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set_tgt_reg <= ufsi_pkg::REG_RST;
        end else if (evt.set_done) begin
            set_tgt_reg <= evt.set_target;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_tgt_reg <= ufsi_pkg::REG_RST;
        end else if (evt.clr_done) begin
            clr_tgt_reg <= evt.clr_target;
        end
    end

    // ==========================================================
    // Endpoint halt state and endpoint 0 masking
    logic [NUM_EP-1:0] halt_reg;
    logic [NUM_EP-1:0] halt_set;
    logic [NUM_EP-1:0] halt_view;
    logic              ep0_mask_reg;

    always_comb begin
        halt_set = evt.stall_vec[NUM_EP-1:0];
        if (wr_force) begin
            halt_set = halt_set | wbyte[NUM_EP-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_reg <= '0;
        end else begin
            halt_reg <= (halt_reg & ~evt.halt_clr_vec[NUM_EP-1:0])
                      | halt_set;
        end
    end

    // The mask opens on a special endpoint 0 request and closes on the
    // next setup token that is not one of them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ep0_mask_reg <= 1'b0;
        end else if (evt.ep0_mask_req) begin
            ep0_mask_reg <= 1'b1;
        end else if (evt.setup_token) begin
            ep0_mask_reg <= 1'b0;
        end
    end

    // Unsupported endpoints read zero rather than a stale halt.
    always_comb begin
        halt_view = halt_reg & endpoint_enable_setting;
        if (ep0_mask_reg) begin
            halt_view[ufsi_pkg::EP0_BIT] = 1'b0;
        end
    end

    // ==========================================================
    // Read data, captured at the edge that drops waitrequest
    logic [ufsi_pkg::DW-1:0] rd_mux;

    always_comb begin
        rd_mux = ufsi_pkg::RD_ZERO;
        case (avm.address)
            ufsi_pkg::BUS_STATE_ADDR: begin
                rd_mux[ufsi_pkg::SUSP_BIT] = susp_reg;
            end
            ufsi_pkg::SRC_FIRST_ADDR: begin
                rd_mux[ufsi_pkg::RW-1:0] =
                    src_flags & ufsi_pkg::SRC_MASK;
            end
            ufsi_pkg::HALT_STAT_ADDR: begin
                rd_mux[NUM_EP-1:0] = halt_view;
            end
            ufsi_pkg::SET_TGT_ADDR: begin
                rd_mux[ufsi_pkg::RW-1:0] = set_tgt_reg;
            end
            ufsi_pkg::CLR_TGT_ADDR: begin
                rd_mux[ufsi_pkg::RW-1:0] = clr_tgt_reg;
            end
            default: begin
                rd_mux = ufsi_pkg::RD_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= ufsi_pkg::RD_ZERO;
        end else if (cap && avm.read) begin
            rdata_reg <= rd_mux;
        end
    end

    // ==========================================================
    // Combined interrupt request
    logic irq_reg;

    // One wire for all sources: clearing one source cannot make a new
    // edge while another stays set, hence the re-read in service.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (|src_flags) | second_sources_any;
        end
    end

    assign combined_usb_irq = irq_reg;
    assign avm_waitrequest  = wait_reg;
    assign avm_readdata     = rdata_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_req_taken;
        (avm.read || avm.write) && avm_waitrequest;
    endsequence

    sequence s_req_answered;
        !avm_waitrequest ##1 avm_waitrequest;
    endsequence

    a_wait_one_cycle: assert property (
        s_req_taken |=> s_req_answered)
        else $error("waitrequest did not pulse low once");

    a_bus_state_read: assert property (
        s_req_taken and (avm.read
        && avm.address == ufsi_pkg::BUS_STATE_ADDR)
        |=> avm_readdata[ufsi_pkg::SUSP_BIT-1:0] == '0
        && avm_readdata[ufsi_pkg::SUSP_BIT] == $past(susp_reg))
        else $error("bus state read data wrong");

    a_read_clears_susp: assert property (
        rd_bus_state && !evt.suspend |=> !susp_reg)
        else $error("suspend bit survived a read");

    a_irq_follows_src: assert property (
        $changed(src_flags) && $past(src_flags) == '0
        |=> combined_usb_irq)
        else $error("source change did not raise irq");

    a_irq_or_all: assert property (
        ##1 combined_usb_irq ==
        ($past(|src_flags) || $past(second_sources_any)))
        else $error("irq is not the OR of sources");

    a_reserved_zero: assert property (
        (src_flags & ~ufsi_pkg::SRC_MASK) == ufsi_pkg::REG_RST)
        else $error("reserved source bits set");

    a_clear_zero_bit: assert property (
        wr_clr && !wbyte[ufsi_pkg::BUS_RST_BIT] && !evt.bus_reset
        |=> !src_flags[ufsi_pkg::BUS_RST_BIT])
        else $error("bus reset flag not cleared");

    a_clear_one_keeps: assert property (
        src_flags[ufsi_pkg::STALL_BIT]
        && !(wr_clr && !wbyte[ufsi_pkg::STALL_BIT])
        |=> src_flags[ufsi_pkg::STALL_BIT])
        else $error("stall flag cleared without a zero write");

    a_bus_reset_sets: assert property (
        evt.bus_reset |=> src_flags[ufsi_pkg::BUS_RST_BIT]
        ##1 combined_usb_irq)
        else $error("bus reset not flagged");

    a_susp_evt_sets: assert property (
        evt.suspend |=> src_flags[ufsi_pkg::RSUSP_BIT] && susp_reg)
        else $error("suspend event not flagged");

    // A resume must both drop the state bit and flag the event.
    a_resume_clears: assert property (
        evt.resume && !evt.suspend
        |=> !susp_reg && src_flags[ufsi_pkg::RSUSP_BIT])
        else $error("resume did not clear suspend state");

    a_set_rq_sets: assert property (
        evt.set_done |=> src_flags[ufsi_pkg::SET_RQ_BIT]
        && set_tgt_reg == $past(evt.set_target))
        else $error("set request not flagged");

    a_setfeat_stall: assert property (
        evt.set_feat_ep |=> src_flags[ufsi_pkg::STALL_BIT])
        else $error("set feature did not flag stall");

    a_clr_rq_sets: assert property (
        evt.clr_done |=> src_flags[ufsi_pkg::CLR_RQ_BIT])
        else $error("clear request not flagged");

    a_stall_sets: assert property (
        (|evt.stall_vec) || force_any
        |=> src_flags[ufsi_pkg::STALL_BIT])
        else $error("stall not flagged");

    a_ep0_masked: assert property (
        evt.ep0_mask_req ##1 !evt.setup_token [*2]
        |-> !halt_view[ufsi_pkg::EP0_BIT])
        else $error("endpoint 0 halt visible while masked");

    a_unsup_zero: assert property (
        (halt_view & ~endpoint_enable_setting) == '0)
        else $error("unsupported endpoint shows halt");
endmodule

// ### testbench/ufsi_sie_model.sv
// Purpose: Far-side event source standing in for the serial engine.
// Assumes: The clock runs whenever an event is sent.
// Notes:   Targets show inverted junk outside done pulses.
`timescale 1ns/10ps
module ufsi_sie_model (
    input  wire logic           clk,
    output ufsi_pkg::ufsi_evt_s evt
);
    // ==========================================================
    // Event pulses
    initial begin
        evt = '0;
    end

    // Events leave only on a running clock, so suspend sampling holds.
    task automatic send(input ufsi_pkg::ufsi_evt_s e);
        ufsi_pkg::ufsi_evt_s idle;
        idle = '0;
        idle.set_target = ~e.set_target;
        idle.clr_target = ~e.clr_target;
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= idle;
    endtask
endmodule

// ### testbench/tb_ufsi_status_irq.sv
// Purpose: Self-checking bench for the USB status and irq block.
// Assumes: Avalon-MM master with one wait cycle per access.
// Notes:   Every wait is bounded; a timeout counts as a mismatch.
`timescale 1ns/10ps
module tb_ufsi_status_irq;
    // ==========================================================
    // Signals
    logic                    clk;
    logic                    rst_n;
    ufsi_pkg::ufsi_avm_req_s avm;
    logic [31:0]             rdata;
    logic                    waitreq;
    ufsi_pkg::ufsi_evt_s     evt;
    ufsi_pkg::ufsi_evt_s     e;
    logic [7:0]              ep_en;
    logic                    sec_any;
    logic                    irq;
    int                      n_mismatch;
    int                      check_count;

    ufsi_status_irq DUT (
        .clk                     (clk),
        .rst_n                   (rst_n),
        .avm                     (avm),
        .avm_readdata            (rdata),
        .avm_waitrequest         (waitreq),
        .evt                     (evt),
        .endpoint_enable_setting (ep_en),
        .second_sources_any      (sec_any),
        .combined_usb_irq        (irq)
    );
    ufsi_sie_model sie (
        .clk (clk),
        .evt (evt)
    );

    initial begin
        clk = 1'b0;
        forever begin
            #4 clk = ~clk;
        end
    end
    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The request is held until waitrequest is sampled low at an edge.
    task automatic bus(input logic wr, input logic [19:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk);
        avm.read <= ~wr;
        avm.write <= wr;
        avm.address <= a;
        avm.writedata <= d;
        avm.byteenable <= 4'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (waitreq === 1'b0) begin
                break;
            end
        end
        if (i == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        q = rdata;
        avm.read <= 1'b0;
        avm.write <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [19:0] a,
                      input logic [7:0] x);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, {24'h0, x});
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] x);
        logic [31:0] q;
        bus(1'b1, a, {24'hffffff, x}, q);
    endtask

    // The irq follows the source register one edge later.
    task automatic irq_chk(input logic x);
        @(posedge clk);
        #1;
        check("irq", {31'h0, irq}, {31'h0, x});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd("bus_state", ufsi_pkg::BUS_STATE_ADDR, 8'h00);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h00);
        rd("unmapped", 20'hf0600, 8'h00);
        irq_chk(1'b0);
        $display("test reset done");
    endtask

    task automatic t_suspend();
        e = '0;
        e.suspend = 1'b1;
        sie.send(e);
        irq_chk(1'b1);
        rd("bus_state", ufsi_pkg::BUS_STATE_ADDR, 8'h80);
        rd("bus_state", ufsi_pkg::BUS_STATE_ADDR, 8'h00);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h40);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'hbf);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h00);
        irq_chk(1'b0);
        $display("test suspend done");
    endtask

    task automatic t_or();
        e = '0;
        e.bus_reset = 1'b1;
        e.resume = 1'b1;
        sie.send(e);
        rd("bus_state", ufsi_pkg::BUS_STATE_ADDR, 8'h00);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'hc0);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'h7f);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h40);
        irq_chk(1'b1);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'hbf);
        irq_chk(1'b0);
        @(posedge clk);
        sec_any <= 1'b1;
        irq_chk(1'b1);
        @(posedge clk);
        sec_any <= 1'b0;
        irq_chk(1'b0);
        $display("test or done");
    endtask

    task automatic t_auto();
        e = '0;
        e.set_done = 1'b1;
        e.set_target = 8'h5a;
        e.set_feat_ep = 1'b1;
        sie.send(e);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h05);
        rd("set_tgt", ufsi_pkg::SET_TGT_ADDR, 8'h5a);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h05);
        e = '0;
        e.clr_done = 1'b1;
        e.clr_target = 8'h33;
        sie.send(e);
        rd("clr_tgt", ufsi_pkg::CLR_TGT_ADDR, 8'h33);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h07);
        wr(ufsi_pkg::SRC_FIRST_ADDR, 8'h00);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h07);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'hff);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h07);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'hfb);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h03);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'hfc);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h00);
        $display("test auto done");
    endtask

    task automatic t_stall();
        e = '0;
        e.stall_vec = 8'h08;
        sie.send(e);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h01);
        rd("halt", ufsi_pkg::HALT_STAT_ADDR, 8'h08);
        e = '0;
        e.setup_token = 1'b1;
        e.halt_clr_vec = 8'h08;
        sie.send(e);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h01);
        @(posedge clk);
        ep_en <= 8'hf7;
        e = '0;
        e.stall_vec = 8'h09;
        e.ep0_mask_req = 1'b1;
        sie.send(e);
        rd("halt", ufsi_pkg::HALT_STAT_ADDR, 8'h00);
        e = '0;
        e.setup_token = 1'b1;
        sie.send(e);
        rd("halt", ufsi_pkg::HALT_STAT_ADDR, 8'h01);
        wr(ufsi_pkg::CLR_FIRST_ADDR, 8'hfe);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h00);
        wr(ufsi_pkg::STALL_FRC_ADDR, 8'h02);
        rd("src_first", ufsi_pkg::SRC_FIRST_ADDR, 8'h01);
        rd("halt", ufsi_pkg::HALT_STAT_ADDR, 8'h03);
        $display("test stall done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        n_mismatch = 0;
        check_count = 0;
        rst_n = 1'b0;
        avm = '0;
        ep_en = 8'hff;
        sec_any = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_suspend();
        t_or();
        t_auto();
        t_stall();
        tally_and_finish();
    end
endmodule
